// File: smpt_map.svh
// register map, field positions and reset values of the pulse timing block
`ifndef SMPT_MAP_SVH
`define SMPT_MAP_SVH

`define SMPT_OFF_PULSE_CS0  32'h400E0074
`define SMPT_OFF_PULSE_CS1  32'h400E0088
`define SMPT_OFF_PULSE_CS2  32'h400E009C
`define SMPT_OFF_PULSE_CS3  32'h400E00B0
`define SMPT_OFF_SETUP      32'h400E0100
`define SMPT_OFF_HOLD       32'h400E0104
`define SMPT_OFF_MODE       32'h400E0108
`define SMPT_OFF_STATUS     32'h400E010C

`define SMPT_PULSE_RESET    32'h01010101
`define SMPT_SETUP_RESET    32'h00000001
`define SMPT_HOLD_RESET     32'h00000001
`define SMPT_MODE_RESET     32'h00000000

`define SMPT_FLD_WE_LSB     0
`define SMPT_FLD_CSWR_LSB   8
`define SMPT_FLD_RD_LSB     16
`define SMPT_FLD_CSRD_LSB   24
`define SMPT_FLD_W          7
`define SMPT_EXT_WEIGHT     9'h100
`define SMPT_MODE_BYTEWR    0

`endif

// File: smpt_pkg.sv
// types shared by the pulse timing block
package smpt_pkg;
  typedef logic [6:0] smpt_field_t;
  typedef logic [8:0] smpt_count_t;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_PULSE,
    ST_HOLD
  } smpt_state_t;
endpackage

// File: smpt_pulse_regs.sv
// four per-chip-select pulse registers with registered read port
`timescale 1ns/100ps
`include "smpt_map.svh"
module smpt_pulse_regs (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        wrEn,
  input  wire logic [1:0]  wrIdx,
  input  wire logic [31:0] wrData,
  input  wire logic [1:0]  rdIdx,
  output logic      [31:0] rdData,
  input  wire logic [1:0]  selIdx,
  output logic      [31:0] selData
);
  logic [31:0] mem_r [4];
  logic [31:0] mem_nxt [4];
  logic [31:0] rdData_nxt;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      mem_nxt[i] = mem_r[i];
    end
    if (wrEn) begin
      mem_nxt[wrIdx] = wrData;
    end
    rdData_nxt = mem_r[rdIdx];
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        mem_r[i] <= `SMPT_PULSE_RESET;
      end
      rdData <= 32'h00000000;
    end else begin
      for (int i = 0; i < 4; i++) begin
        mem_r[i] <= mem_nxt[i];
      end
      rdData <= rdData_nxt;
    end
  end

  assign selData = mem_r[selIdx];
endmodule

// File: smpt_strobe_cnt.sv
// down counter for one strobe phase
`timescale 1ns/100ps
module smpt_strobe_cnt (
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  input  wire logic                 load,
  input  wire smpt_pkg::smpt_count_t loadVal,
  output logic                      done
);
  smpt_pkg::smpt_count_t cnt_r;
  smpt_pkg::smpt_count_t cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = loadVal;
    end else if (cnt_r != 9'h000) begin
      cnt_nxt = cnt_r - 9'h001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_r <= 9'h000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // last cycle of the phase when one or none remains
  assign done = (cnt_r == 9'h001) || (cnt_r == 9'h000);
endmodule

// File: smpt_ctrl.sv
// static memory pulse timing controller with apb register port
//
// Contract
// - write setup phase drives address and data before write strobe falls.
// - write pulse runs from write strobe falling edge to rising edge.
// - write hold keeps address and data driven after strobe rises.
// - byte-write mode gives only the byte strobes enabled by accByteEn the write strobe waveform.
// - write strobe low for 256*field[6] plus field[5:0] cycles.
// - write chip select active 256*field[6] plus field[5:0] cycles.
// - read strobe low for 256*field[6] plus field[5:0] cycles.
// - read chip select active 256*field[6] plus field[5:0] cycles.
`timescale 1ns/100ps
`include "smpt_map.svh"
module smpt_ctrl (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        accReq,
  input  wire logic        accWrite,
  input  wire logic [1:0]  accCs,
  input  wire logic [3:0]  accByteEn,
  input  wire logic [31:0] accAddr,
  input  wire logic [31:0] accWdata,
  output logic             accBusy,
  output logic             accDone,
  output logic      [3:0]  chipSelect_n,
  output logic             writeStrobe_n,
  output logic      [3:0]  byteWriteStrobes_n,
  output logic             readStrobe_n,
  output logic      [31:0] memAddr,
  output logic      [31:0] memWdata,
  output logic             memDataOe
);
  // pulse length from a 7-bit field with extended high bit
  function automatic smpt_pkg::smpt_count_t pulseLen(
    input smpt_pkg::smpt_field_t f
  );
    smpt_pkg::smpt_count_t ext;
    ext = f[6] ? `SMPT_EXT_WEIGHT : 9'h000;
    pulseLen = ext + {3'b000, f[5:0]};
  endfunction

  // register index decode, used by the slave port
  function automatic logic [2:0] regIdx(input logic [31:0] a);
    case (a)
      `SMPT_OFF_PULSE_CS0: regIdx = 3'h0;
      `SMPT_OFF_PULSE_CS1: regIdx = 3'h1;
      `SMPT_OFF_PULSE_CS2: regIdx = 3'h2;
      `SMPT_OFF_PULSE_CS3: regIdx = 3'h3;
      `SMPT_OFF_SETUP:     regIdx = 3'h4;
      `SMPT_OFF_HOLD:      regIdx = 3'h5;
      `SMPT_OFF_MODE:      regIdx = 3'h6;
      `SMPT_OFF_STATUS:    regIdx = 3'h7;
      default:             regIdx = 3'h0;
    endcase
  endfunction

  function automatic logic mapped(input logic [31:0] a);
    mapped = (a == `SMPT_OFF_PULSE_CS0) || (a == `SMPT_OFF_PULSE_CS1) ||
             (a == `SMPT_OFF_PULSE_CS2) || (a == `SMPT_OFF_PULSE_CS3) ||
             (a == `SMPT_OFF_SETUP) || (a == `SMPT_OFF_HOLD) ||
             (a == `SMPT_OFF_MODE) || (a == `SMPT_OFF_STATUS);
  endfunction

  // ---- apb slave ----
  logic        apbAccess;
  logic [2:0]  idx;
  logic        pulseWrEn;
  logic [31:0] pulseRd;
  logic [31:0] pulseSel;
  logic [31:0] setup_r;
  logic [31:0] setup_nxt;
  logic [31:0] hold_r;
  logic [31:0] hold_nxt;
  logic [31:0] mode_r;
  logic [31:0] mode_nxt;
  logic [2:0]  rdIdx_r;
  logic [2:0]  rdIdx_nxt;
  logic        pready_nxt;
  logic        pslverr_nxt;
  logic        rdPend_r;
  logic        rdPend_nxt;
  logic [31:0] prdata_nxt;

  assign apbAccess = psel && penable && !pready;
  assign idx       = regIdx(paddr);
  assign pulseWrEn = apbAccess && pwrite && mapped(paddr) && !idx[2];

  // state of the strobe sequencer, declared early for the status read
  smpt_pkg::smpt_state_t state_r;
  smpt_pkg::smpt_state_t state_nxt;
  logic [1:0]            accCs_r;
  logic [1:0]            accCs_nxt;
  logic                  accWrite_r;
  logic                  accWrite_nxt;

  smpt_pulse_regs uRegs (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .wrEn    (pulseWrEn),
    .wrIdx   (idx[1:0]),
    .wrData  (pwdata),
    .rdIdx   (idx[1:0]),
    .rdData  (pulseRd),
    .selIdx  (accCs_r),
    .selData (pulseSel)
  );

  // reads finish one cycle after the access phase so regs data is registered
  always_comb begin
    setup_nxt   = setup_r;
    hold_nxt    = hold_r;
    mode_nxt    = mode_r;
    rdIdx_nxt   = rdIdx_r;
    rdPend_nxt  = 1'b0;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt  = prdata;
    if (rdPend_r) begin
      pready_nxt = 1'b1;
      case (rdIdx_r)
        3'h4:    prdata_nxt = setup_r;
        3'h5:    prdata_nxt = hold_r;
        3'h6:    prdata_nxt = mode_r;
        3'h7:    prdata_nxt = {29'h0, accWrite_r, accBusy, accDone};
        default: prdata_nxt = pulseRd;
      endcase
    end else if (apbAccess && !rdPend_r) begin
      if (!mapped(paddr)) begin
        pready_nxt  = 1'b1;
        pslverr_nxt = 1'b1;
        prdata_nxt  = 32'h00000000;
      end else if (pwrite) begin
        pready_nxt = 1'b1;
        case (idx)
          3'h4:    setup_nxt = {25'h0, pwdata[6:0]};
          3'h5:    hold_nxt  = {25'h0, pwdata[6:0]};
          3'h6:    mode_nxt  = {31'h0, pwdata[0]};
          default: mode_nxt  = mode_r;
        endcase
      end else begin
        rdIdx_nxt  = idx;
        rdPend_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      setup_r <= `SMPT_SETUP_RESET;
      hold_r  <= `SMPT_HOLD_RESET;
      mode_r  <= `SMPT_MODE_RESET;
      rdIdx_r <= 3'h0;
      rdPend_r <= 1'b0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      setup_r <= setup_nxt;
      hold_r  <= hold_nxt;
      mode_r  <= mode_nxt;
      rdIdx_r <= rdIdx_nxt;
      rdPend_r <= rdPend_nxt;
      pready  <= pready_nxt;
      pslverr <= pslverr_nxt;
      prdata  <= prdata_nxt;
    end
  end

  // ---- strobe sequencer ----
  smpt_pkg::smpt_field_t weField;
  smpt_pkg::smpt_field_t csWrField;
  smpt_pkg::smpt_field_t rdField;
  smpt_pkg::smpt_field_t csRdField;
  assign weField   = pulseSel[`SMPT_FLD_WE_LSB +: `SMPT_FLD_W];
  assign csWrField = pulseSel[`SMPT_FLD_CSWR_LSB +: `SMPT_FLD_W];
  assign rdField   = pulseSel[`SMPT_FLD_RD_LSB +: `SMPT_FLD_W];
  assign csRdField = pulseSel[`SMPT_FLD_CSRD_LSB +: `SMPT_FLD_W];

  logic                  phLoad;
  smpt_pkg::smpt_count_t phVal;
  logic                  phDone;
  logic                  csLoad;
  smpt_pkg::smpt_count_t csVal;
  logic                  csDone;
  logic                  csOn_r;
  logic                  csOn_nxt;
  logic                  strobeOn_r;
  logic                  strobeOn_nxt;
  logic [3:0]            be_r;
  logic [3:0]            be_nxt;
  logic [31:0]           addr_nxt;
  logic [31:0]           wdata_nxt;
  logic                  oe_nxt;
  logic                  done_nxt;
  logic                  busy_nxt;

  smpt_strobe_cnt uPhase (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .load    (phLoad),
    .loadVal (phVal),
    .done    (phDone)
  );

  smpt_strobe_cnt uCs (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .load    (csLoad),
    .loadVal (csVal),
    .done    (csDone)
  );

  // setup count, loaded as the access is taken
  logic       setupLoad;
  logic [6:0] setupCnt_r;
  logic [6:0] setupCnt_nxt;
  logic       strobeGo;
  assign setupLoad = (state_r == smpt_pkg::ST_IDLE) && accReq;
  // strobe falls at the end of the last setup cycle; a zero count acts as one
  assign strobeGo = (state_r == smpt_pkg::ST_SETUP) && (setupCnt_r <= 7'h01);
  always_comb begin
    setupCnt_nxt = setupCnt_r;
    if (setupLoad) begin
      setupCnt_nxt = setup_r[6:0];
    end else if (setupCnt_r != 7'h00) begin
      setupCnt_nxt = setupCnt_r - 7'h01;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      setupCnt_r <= 7'h00;
    end else begin
      setupCnt_r <= setupCnt_nxt;
    end
  end

  always_comb begin
    state_nxt    = state_r;
    accCs_nxt    = accCs_r;
    accWrite_nxt = accWrite_r;
    be_nxt       = be_r;
    addr_nxt     = memAddr;
    wdata_nxt    = memWdata;
    oe_nxt       = memDataOe;
    strobeOn_nxt = strobeOn_r;
    csOn_nxt     = csOn_r && !csDone;
    phLoad       = 1'b0;
    phVal        = 9'h000;
    csLoad       = 1'b0;
    csVal        = 9'h000;
    done_nxt     = 1'b0;
    busy_nxt     = accBusy;
    case (state_r)
      smpt_pkg::ST_IDLE: begin
        if (accReq) begin
          accCs_nxt    = accCs;
          accWrite_nxt = accWrite;
          be_nxt       = accByteEn;
          addr_nxt     = accAddr;
          wdata_nxt    = accWdata;
          oe_nxt       = accWrite;
          busy_nxt     = 1'b1;
          state_nxt    = smpt_pkg::ST_SETUP;
        end
      end
      smpt_pkg::ST_SETUP: begin
        // address and data lead the strobe for the setup count
        if (strobeGo) begin
          phLoad       = 1'b1;
          csLoad       = 1'b1;
          csOn_nxt     = 1'b1;
          strobeOn_nxt = 1'b1;
          phVal = accWrite_r ? pulseLen(weField) : pulseLen(rdField);
          csVal = accWrite_r ? pulseLen(csWrField)
                             : pulseLen(csRdField);
          state_nxt = smpt_pkg::ST_PULSE;
        end
      end
      smpt_pkg::ST_PULSE: begin
        if (phDone) begin
          strobeOn_nxt = 1'b0;
          phLoad       = 1'b1;
          phVal        = {2'b00, hold_r[6:0]};
          state_nxt    = smpt_pkg::ST_HOLD;
        end
      end
      smpt_pkg::ST_HOLD: begin
        if (phDone && !csOn_r) begin
          oe_nxt    = 1'b0;
          done_nxt  = 1'b1;
          busy_nxt  = 1'b0;
          state_nxt = smpt_pkg::ST_IDLE;
        end
      end
      default: state_nxt = smpt_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r    <= smpt_pkg::ST_IDLE;
      accCs_r    <= 2'h0;
      accWrite_r <= 1'b0;
      be_r       <= 4'h0;
      csOn_r     <= 1'b0;
      strobeOn_r <= 1'b0;
      memAddr    <= 32'h00000000;
      memWdata   <= 32'h00000000;
      memDataOe  <= 1'b0;
      accDone    <= 1'b0;
      accBusy    <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      accCs_r    <= accCs_nxt;
      accWrite_r <= accWrite_nxt;
      be_r       <= be_nxt;
      csOn_r     <= csOn_nxt;
      strobeOn_r <= strobeOn_nxt;
      memAddr    <= addr_nxt;
      memWdata   <= wdata_nxt;
      memDataOe  <= oe_nxt;
      accDone    <= done_nxt;
      accBusy    <= busy_nxt;
    end
  end

  // ---- pin outputs, all registered ----
  logic [3:0] csN_nxt;
  logic       weN_nxt;
  logic       rdN_nxt;
  logic [3:0] bwN_nxt;

  always_comb begin
    csN_nxt = 4'hF;
    weN_nxt = 1'b1;
    rdN_nxt = 1'b1;
    bwN_nxt = 4'hF;
    if (csOn_nxt) begin
      csN_nxt[accCs_r] = 1'b0;
    end
    if (strobeOn_nxt) begin
      if (!accWrite_r) begin
        rdN_nxt = 1'b0;
      end else if (mode_r[`SMPT_MODE_BYTEWR]) begin
        bwN_nxt = ~be_r;
      end else begin
        weN_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      chipSelect_n       <= 4'hF;
      writeStrobe_n      <= 1'b1;
      readStrobe_n       <= 1'b1;
      byteWriteStrobes_n <= 4'hF;
    end else begin
      chipSelect_n       <= csN_nxt;
      writeStrobe_n      <= weN_nxt;
      readStrobe_n       <= rdN_nxt;
      byteWriteStrobes_n <= bwN_nxt;
    end
  end
endmodule

// File: smpt_ctrl_monitor.sv
// port checker for the pulse timing controller
`timescale 1ns/100ps
`include "smpt_map.svh"
module smpt_ctrl_monitor (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        accReq,
  input wire logic        accWrite,
  input wire logic [1:0]  accCs,
  input wire logic [3:0]  accByteEn,
  input wire logic [31:0] accAddr,
  input wire logic        accBusy,
  input wire logic        accDone,
  input wire logic [3:0]  chipSelect_n,
  input wire logic        writeStrobe_n,
  input wire logic [3:0]  byteWriteStrobes_n,
  input wire logic        readStrobe_n,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memWdata,
  input wire logic        memDataOe
);
  localparam logic [31:0] ADR [4] = '{`SMPT_OFF_PULSE_CS0,
    `SMPT_OFF_PULSE_CS1, `SMPT_OFF_PULSE_CS2, `SMPT_OFF_PULSE_CS3};
  logic [31:0] sh_r [4];
  logic [31:0] sh_nxt [4];
  logic [31:0] cur, ad_r, ad_nxt;
  logic [9:0]  wc_r, wc_nxt, cc_r, cc_nxt, rc_r, rc_nxt;
  logic [3:0]  be_r, be_nxt;
  logic [1:0]  cs_r, cs_nxt;
  logic        mode_r, mode_nxt, wr_r, wr_nxt, wLow, csLow;
  assign wLow  = !writeStrobe_n || (byteWriteStrobes_n != 4'hF);
  assign csLow = chipSelect_n != 4'hF;
  assign cur   = sh_r[cs_r];
  function automatic logic [9:0] plen(input logic [6:0] f);
    return {1'h0, f[6], 2'h0, f[5:0]};
  endfunction
  // shadow of programmed lengths and of the accepted access
  always_comb begin
    sh_nxt = sh_r;
    mode_nxt = mode_r;
    cs_nxt = cs_r;
    wr_nxt = wr_r;
    be_nxt = be_r;
    ad_nxt = ad_r;
    if (psel && penable && pready && pwrite) begin
      for (int i = 0; i < 4; i++) begin
        if (paddr == ADR[i]) sh_nxt[i] = pwdata;
      end
      if (paddr == `SMPT_OFF_MODE) mode_nxt = pwdata[`SMPT_MODE_BYTEWR];
    end
    if (accReq && !accBusy) begin
      cs_nxt = accCs;
      wr_nxt = accWrite;
      be_nxt = accByteEn;
      ad_nxt = accAddr;
    end
    wc_nxt = wLow ? wc_r + 10'h1 : 10'h0;
    cc_nxt = csLow ? cc_r + 10'h1 : 10'h0;
    rc_nxt = !readStrobe_n ? rc_r + 10'h1 : 10'h0;
  end
  always_ff @(posedge clk_sys) begin
    cs_r <= cs_nxt;
    wr_r <= wr_nxt;
    be_r <= be_nxt;
    ad_r <= ad_nxt;
    if (sys_rst) begin
      sh_r <= '{default: `SMPT_PULSE_RESET};
      mode_r <= 1'h0;
      wc_r <= 10'h0;
      cc_r <= 10'h0;
      rc_r <= 10'h0;
    end else begin
      sh_r <= sh_nxt;
      mode_r <= mode_nxt;
      wc_r <= wc_nxt;
      cc_r <= cc_nxt;
      rc_r <= rc_nxt;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence sWEnd; wLow ##1 !wLow; endsequence
  sequence sCsEnd; csLow ##1 !csLow; endsequence
  sequence sREnd; !readStrobe_n ##1 readStrobe_n; endsequence
  AST_WE_LEN: assert property (
    sWEnd |-> wc_r == plen(cur[6:0])) else $error("write strobe length");
  AST_CS_WR_LEN: assert property (
    wr_r ##0 sCsEnd |-> cc_r == plen(cur[14:8]))
    else $error("write chip select length");
  AST_RD_LEN: assert property (
    sREnd |-> rc_r == plen(cur[22:16])) else $error("read strobe length");
  AST_CS_RD_LEN: assert property (
    !wr_r ##0 sCsEnd |-> cc_r == plen(cur[30:24]))
    else $error("read chip select length");
  AST_CS_SEL: assert property (
    csLow |-> chipSelect_n == ~(4'h1 << cs_r)) else $error("wrong select");
  AST_BYTE: assert property (
    (byteWriteStrobes_n != 4'hF) |-> mode_r && byteWriteStrobes_n == ~be_r)
    else $error("byte strobes wrong");
  AST_SETUP: assert property (
    $rose(wLow) |-> memDataOe && memAddr == ad_r) else $error("no setup");
  AST_HOLD: assert property (
    $fell(wLow) |-> memDataOe && $stable(memWdata)) else $error("no hold");
  AST_DONE: assert property (
    accDone |=> !accDone && !csLow) else $error("done pulse wrong");
endmodule

// File: smpt_mem_model.sv
// external static memory model that measures strobe widths
`timescale 1ns/100ps
module smpt_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        clr,
  input  wire logic [3:0]  chipSelect_n,
  input  wire logic        writeStrobe_n,
  input  wire logic [3:0]  byteWriteStrobes_n,
  input  wire logic        readStrobe_n,
  input  wire logic        memDataOe,
  input  wire logic [31:0] memWdata,
  output logic      [31:0] weLen,
  output logic      [31:0] rdLen,
  output logic      [31:0] csLen,
  output logic      [3:0]  csMask,
  output logic      [3:0]  bwMask,
  output logic      [31:0] lastData,
  output logic      [7:0]  setupLen,
  output logic      [7:0]  holdLen,
  output logic             setupOk,
  output logic             holdOk
);
  logic [31:0] wc, rc, cc;
  logic        wl, wp;
  logic [7:0]  sc;
  assign wl = !writeStrobe_n || (byteWriteStrobes_n != 4'hF);
  always_ff @(posedge clk_sys) begin
    wp <= wl;
    wc <= wl ? wc + 32'h1 : 32'h0;
    rc <= !readStrobe_n ? rc + 32'h1 : 32'h0;
    cc <= (chipSelect_n != 4'hF) ? cc + 32'h1 : 32'h0;
    // cycles with data driven and strobe high, before and after the pulse
    sc <= (memDataOe && !wl) ? sc + 8'h1 : 8'h0;
    if (wl && !wp) setupLen <= sc;
    if (!memDataOe && sc != 8'h0) holdLen <= sc;
    if (!wl && wc != 32'h0) weLen <= wc;
    if (readStrobe_n && rc != 32'h0) rdLen <= rc;
    if (chipSelect_n == 4'hF && cc != 32'h0) csLen <= cc;
    csMask <= csMask | ~chipSelect_n;
    bwMask <= bwMask | ~byteWriteStrobes_n;
    if (wl && !wp) setupOk <= memDataOe;
    if (!wl && wp) begin
      holdOk <= memDataOe;
      lastData <= memWdata;
    end
    if (clr) begin
      {weLen, rdLen, csLen, setupLen, holdLen} <= '0;
      {csMask, bwMask, setupOk, holdOk} <= '0;
    end
  end
endmodule

// File: tb_smpt_ctrl.sv
// self-checking bench for the pulse timing controller
`timescale 1ns/100ps
`include "smpt_map.svh"
module tb_smpt_ctrl;
  localparam logic [31:0] ADR [4] = '{`SMPT_OFF_PULSE_CS0,
    `SMPT_OFF_PULSE_CS1, `SMPT_OFF_PULSE_CS2, `SMPT_OFF_PULSE_CS3};
  logic        clk_sys, sys_rst, psel, penable, pwrite, accReq, accWrite, clr;
  logic [31:0] paddr, pwdata, accAddr, accWdata;
  logic [1:0]  accCs;
  logic [3:0]  accByteEn;
  wire  [31:0] prdata, memAddr, memWdata, weLen, rdLen, csLen, lastData;
  wire  [3:0]  chipSelect_n, byteWriteStrobes_n, csMask, bwMask;
  wire         pready, pslverr, accBusy, accDone, writeStrobe_n;
  wire         readStrobe_n, memDataOe, setupOk, holdOk;
  wire  [7:0]  setupLen, holdLen;
  int          errors, num_checks;

  smpt_ctrl DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .accReq(accReq),
    .accWrite(accWrite), .accCs(accCs), .accByteEn(accByteEn),
    .accAddr(accAddr), .accWdata(accWdata), .accBusy(accBusy),
    .accDone(accDone), .chipSelect_n(chipSelect_n),
    .writeStrobe_n(writeStrobe_n), .byteWriteStrobes_n(byteWriteStrobes_n),
    .readStrobe_n(readStrobe_n), .memAddr(memAddr), .memWdata(memWdata),
    .memDataOe(memDataOe));
  smpt_mem_model u_mem (.clk_sys(clk_sys), .clr(clr),
    .chipSelect_n(chipSelect_n), .writeStrobe_n(writeStrobe_n),
    .byteWriteStrobes_n(byteWriteStrobes_n), .readStrobe_n(readStrobe_n),
    .memDataOe(memDataOe), .memWdata(memWdata), .weLen(weLen),
    .rdLen(rdLen), .csLen(csLen), .csMask(csMask), .bwMask(bwMask),
    .lastData(lastData), .setupOk(setupOk), .holdOk(holdOk),
    .setupLen(setupLen), .holdLen(holdLen));

  initial begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] plen(input logic [6:0] f);
    return {23'h0, f[6], 2'h0, f[5:0]};
  endfunction

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic er);
    int n;
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'h1 && n < 50);
    r = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 50) chk("pready", 32'h1, 32'h0);
  endtask

  task automatic acc(input logic w, input logic [1:0] cs, input logic [3:0] be);
    int n;
    @(posedge clk_sys);
    clr <= 1'h1;
    accReq <= 1'h1;
    accWrite <= w;
    accCs <= cs;
    accByteEn <= be;
    accAddr <= 32'h2000 + 32'(cs);
    accWdata <= ~(32'h2000 + 32'(cs));
    @(posedge clk_sys);
    clr <= 1'h0;
    accReq <= 1'h0;
    @(posedge clk_sys);
    chk("busy", 32'h1, 32'(accBusy));
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (accDone !== 1'h1 && n < 2000);
    if (n >= 2000) chk("accDone", 32'h1, 32'h0);
    chk("idle", 32'h0, 32'(accBusy));
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    for (int i = 0; i < 4; i++) begin
      apb(1'h0, ADR[i], 32'h0, r, e);
      chk("pulse_reset", `SMPT_PULSE_RESET, r);
    end
    apb(1'h1, 32'h400E0070, 32'hFFFFFFFF, r, e);
    chk("wr_err", 32'h1, 32'(e));
    apb(1'h0, 32'h400E0070, 32'h0, r, e);
    chk("rd_err", 32'h1, 32'(e));
    chk("rd_zero", 32'h0, r);
  endtask

  task automatic t_wr(input logic [1:0] cs, input logic [6:0] we, cw,
                      input logic [3:0] be, input logic bm);
    logic [31:0] r, v;
    logic        e;
    v = {16'h0101, 1'h0, cw, 1'h0, we};
    apb(1'h1, ADR[cs], v, r, e);
    apb(1'h0, ADR[cs], 32'h0, r, e);
    chk("pulse_rb", v, r);
    acc(1'h1, cs, be);
    chk("we_len", plen(we), weLen);
    chk("cs_wr_len", plen(cw), csLen);
    chk("cs_mask", 32'(4'h1 << cs), 32'(csMask));
    chk("byte_mask", bm ? 32'(be) : 32'h0, 32'(bwMask));
    chk("setup", 32'h1, 32'(setupOk));
    chk("hold", 32'h1, 32'(holdOk));
    chk("wdata", ~accAddr, lastData);
  endtask

  task automatic t_rd(input logic [1:0] cs, input logic [6:0] rd, cr);
    logic [31:0] r;
    logic        e;
    apb(1'h1, ADR[cs], {1'h0, cr, 1'h0, rd, 16'h0101}, r, e);
    acc(1'h0, cs, 4'hF);
    chk("rd_len", plen(rd), rdLen);
    chk("cs_rd_len", plen(cr), csLen);
    chk("cs_mask", 32'(4'h1 << cs), 32'(csMask));
    chk("no_write", 32'h0, weLen);
  endtask

  task automatic t_byte();
    logic [31:0] r;
    logic        e;
    apb(1'h1, `SMPT_OFF_MODE, 32'h1, r, e);
    apb(1'h0, `SMPT_OFF_MODE, 32'h0, r, e);
    chk("mode_rb", 32'h1, r);
    t_wr(2'h1, 7'h04, 7'h06, 4'h5, 1'h1);
    apb(1'h1, `SMPT_OFF_MODE, 32'h0, r, e);
  endtask

  task automatic t_sh();
    logic [31:0] r;
    logic        e;
    apb(1'h1, `SMPT_OFF_SETUP, 32'h3, r, e);
    apb(1'h1, `SMPT_OFF_HOLD, 32'h2, r, e);
    apb(1'h0, `SMPT_OFF_SETUP, 32'h0, r, e);
    chk("setup_rb", 32'h3, r);
    apb(1'h0, `SMPT_OFF_HOLD, 32'h0, r, e);
    chk("hold_rb", 32'h2, r);
    t_wr(2'h2, 7'h02, 7'h02, 4'hF, 1'h0);
    chk("setup_len", 32'h3, 32'(setupLen));
    chk("hold_len", 32'h2, 32'(holdLen));
    apb(1'h0, `SMPT_OFF_STATUS, 32'h0, r, e);
    chk("status", 32'h4, r);
  endtask

  task automatic complete_run();
    if (errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    {psel, penable, pwrite, accReq, accWrite, clr} = '0;
    {paddr, pwdata, accAddr, accWdata} = '0;
    accCs = 2'h0;
    accByteEn = 4'h0;
    sys_rst = 1'h1;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'h0;
    t_regs();
    t_wr(2'h0, 7'h03, 7'h05, 4'hF, 1'h0);
    t_wr(2'h1, 7'h41, 7'h43, 4'hF, 1'h0);
    t_wr(2'h2, 7'h01, 7'h01, 4'hF, 1'h0);
    t_wr(2'h3, 7'h3F, 7'h40, 4'hF, 1'h0);
    t_rd(2'h0, 7'h02, 7'h04);
    t_rd(2'h1, 7'h40, 7'h41);
    t_rd(2'h2, 7'h01, 7'h01);
    t_rd(2'h3, 7'h45, 7'h7F);
    t_byte();
    t_sh();
    complete_run();
  end

  initial begin
    repeat (50000) @(posedge clk_sys);
    errors++;
    complete_run();
  end
endmodule

bind smpt_ctrl smpt_ctrl_monitor u_mon (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .accReq(accReq), .accWrite(accWrite),
  .accCs(accCs), .accByteEn(accByteEn), .accAddr(accAddr),
  .accBusy(accBusy), .accDone(accDone), .chipSelect_n(chipSelect_n),
  .writeStrobe_n(writeStrobe_n), .byteWriteStrobes_n(byteWriteStrobes_n),
  .readStrobe_n(readStrobe_n), .memAddr(memAddr), .memWdata(memWdata),
  .memDataOe(memDataOe));
